/* ict_defs.vh */
`ifndef ICT_DEFS_VH
`define ICT_DEFS_VH
// System clocks per instruction cycle
`define ICT_SYS_PER_INSTR 4
`define ICT_PHASE_W 2
`define ICT_PHASE_LAST 2'h3
// Reset values of the sequencing outputs
`define ICT_RST_EXEC_VALID 1'b1
`define ICT_RST_FLUSH 1'b0
// Instruction cycle counts reported on cycles_o
`define ICT_CYCLES_ONE 2'h1
`define ICT_CYCLES_TWO 2'h2
// Instruction class codes
`define ICT_CLS_W 3
`define ICT_CLS_PLAIN 3'h0
`define ICT_CLS_JUMP 3'h1
`define ICT_CLS_CALL 3'h2
`define ICT_CLS_RET 3'h3
`define ICT_CLS_RETURN_FROM_INTERRUPT_OP 3'h4
`define ICT_CLS_TABLE 3'h5
`define ICT_CLS_SKIP 3'h6
`endif

/* ict_phase_div.v */
`timescale 1ns/1ps
`include "ict_defs.vh"
module ict_phase_div #(
   parameter PHASE_W = `ICT_PHASE_W
) (
   input wire core_clk_i,
   input wire nrst_i,
   output wire [PHASE_W-1:0] phase_o,
   output wire cycle_end_o
);
   reg [PHASE_W-1:0] phase_r;
   // Counter wraps on its own, so the phase count must be a power of two
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         phase_r <= {PHASE_W{1'b0}};
      end else begin
         phase_r <= phase_r + {{(PHASE_W-1){1'b0}}, 1'b1};
      end
   end
   assign phase_o = phase_r;
   assign cycle_end_o = (phase_r == {PHASE_W{1'b1}});
endmodule

/* ict_instr_timing.v */
`timescale 1ns/1ps
`include "ict_defs.vh"
module ict_instr_timing #(
   parameter PHASE_W = `ICT_PHASE_W,
   parameter CLS_W = `ICT_CLS_W
) (
   input wire core_clk_i,
   input wire nrst_i,
   input wire [CLS_W-1:0] instr_class_i,
   input wire pcl_write_i,
   input wire skip_taken_i,
   output wire [PHASE_W-1:0] phase_o,
   output wire instr_cycle_end_o,
   output wire instr_start_o,
   output reg exec_valid_o,
   output reg flush_o,
   output reg [1:0] cycles_o
);
   // Sequencing states: first cycle of an instruction, or its extra cycle
   localparam ST_FIRST = 1'b0;
   localparam ST_EXTRA = 1'b1;

   wire [PHASE_W-1:0] phase;
   wire cyc_end;
   reg state_r;
   reg state_nxt;
   reg extra_nxt;
   reg exec_valid_nxt;
   reg flush_nxt;
   reg [1:0] cycles_nxt;

   function is_two_cycle;
      input [CLS_W-1:0] cls;
      begin
         case (cls)
            `ICT_CLS_JUMP: begin
               is_two_cycle = 1'b1;
            end
            `ICT_CLS_CALL: begin
               is_two_cycle = 1'b1;
            end
            `ICT_CLS_RET: begin
               is_two_cycle = 1'b1;
            end
            `ICT_CLS_RETURN_FROM_INTERRUPT_OP: begin
               is_two_cycle = 1'b1;
            end
            `ICT_CLS_TABLE: begin
               is_two_cycle = 1'b1;
            end
            default: begin
               is_two_cycle = 1'b0;
            end
         endcase
      end
   endfunction

   function is_skip;
      input [CLS_W-1:0] cls;
      begin
         case (cls)
            `ICT_CLS_SKIP: begin
               is_skip = 1'b1;
            end
            default: begin
               is_skip = 1'b0;
            end
         endcase
      end
   endfunction

   // Extra cycle is never doubled: a branch that also writes the counter costs one extra
   function needs_extra;
      input [CLS_W-1:0] cls;
      input pclw;
      input skp;
      begin
         needs_extra = 1'b0;
         if (pclw) begin
            needs_extra = 1'b1;
         end else if (is_two_cycle(cls)) begin
            needs_extra = 1'b1;
         end else if (is_skip(cls)) begin
            needs_extra = skp;
         end else begin
            needs_extra = 1'b0;
         end
      end
   endfunction

   ict_phase_div #(
      .PHASE_W(PHASE_W)
   ) ict_phase_div_inst (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .phase_o(phase),
      .cycle_end_o(cyc_end)
   );

   assign phase_o = phase;
   assign instr_cycle_end_o = cyc_end;

   assign instr_start_o = cyc_end & ~extra_nxt;

   // Inputs only matter in the last phase of a first cycle
   always @* begin
      extra_nxt = 1'b0;
      case (state_r)
         ST_FIRST: begin
            extra_nxt = needs_extra(instr_class_i, pcl_write_i, skip_taken_i);
         end
         ST_EXTRA: begin
            // Discarded slot never asks for a further cycle
            extra_nxt = 1'b0;
         end
         default: begin
            extra_nxt = 1'b0;
         end
      endcase
   end

   always @* begin
      state_nxt = state_r;
      exec_valid_nxt = exec_valid_o;
      flush_nxt = flush_o;
      cycles_nxt = cycles_o;
      if (cyc_end) begin
         case (state_r)
            ST_FIRST: begin
               if (extra_nxt) begin
                  state_nxt = ST_EXTRA;
                  exec_valid_nxt = 1'b0;
                  flush_nxt = 1'b1;
                  cycles_nxt = `ICT_CYCLES_TWO;
               end else begin
                  state_nxt = ST_FIRST;
                  exec_valid_nxt = 1'b1;
                  flush_nxt = 1'b0;
                  cycles_nxt = `ICT_CYCLES_ONE;
               end
            end
            ST_EXTRA: begin
               // Count of the finished instruction stays visible
               state_nxt = ST_FIRST;
               exec_valid_nxt = 1'b1;
               flush_nxt = 1'b0;
               cycles_nxt = cycles_o;
            end
            default: begin
               state_nxt = ST_FIRST;
               exec_valid_nxt = 1'b1;
               flush_nxt = 1'b0;
               cycles_nxt = `ICT_CYCLES_ONE;
            end
         endcase
      end
   end

   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= ST_FIRST;
         exec_valid_o <= `ICT_RST_EXEC_VALID;
         flush_o <= `ICT_RST_FLUSH;
         cycles_o <= `ICT_CYCLES_ONE;
      end else begin
         state_r <= state_nxt;
         exec_valid_o <= exec_valid_nxt;
         flush_o <= flush_nxt;
         cycles_o <= cycles_nxt;
      end
   end
endmodule

/* ict_chk_sva.sv */
`timescale 1ns/1ps
module ict_chk(input wire core_clk_i,nrst_i,pcl_write_i,skip_taken_i,flush_o,exec_valid_o,
   input wire [2:0] instr_class_i,input wire [1:0] phase_o,cycles_o);
default clocking @(posedge core_clk_i); endclocking
default disable iff (!nrst_i);
wire t=phase_o==2'h3&&!flush_o;
a_phase_step: assert property ($past(nrst_i)|->phase_o==$past(phase_o)+2'h1) else $error("phase");
a_plain_one: assert property (t&&instr_class_i==3'h0&&!pcl_write_i|=>!flush_o&&cycles_o==2'h1) else $error("one");
a_branch_two: assert property (t&&instr_class_i inside {[1:5]}|=>flush_o[*4]##1!flush_o) else $error("two");
a_pcl_extra: assert property (t&&pcl_write_i|=>flush_o&&cycles_o==2'h2) else $error("pcl");
a_skip_count: assert property (t&&instr_class_i==3'h6&&!pcl_write_i|=>flush_o==$past(skip_taken_i)) else $error("skip");
a_nop_extra: assert property (flush_o|->!exec_valid_o) else $error("nop");
a_flush_rise: assert property ($rose(flush_o)|->phase_o==2'h0&&$past(phase_o)==2'h3) else $error("rise");
a_flush_fall: assert property ($fell(flush_o)|->phase_o==2'h0&&exec_valid_o) else $error("fall");
endmodule
bind ict_instr_timing ict_chk ict_chk_inst(.*);

/* ict_instr_timing_tb.sv */
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if((a)!==(b)) begin errors++; $display("Error %0t bad",$time); end end
module ict_instr_timing_tb;
logic core_clk_i=0,nrst_i=0,pcl_write_i=0,skip_taken_i=0;
logic [2:0] instr_class_i=0;
wire [1:0] phase_o,cycles_o;
wire instr_cycle_end_o,instr_start_o,exec_valid_o,flush_o;
int errors=0,checks_done=0;
ict_instr_timing ict_instr_timing_inst(.*);
always #10 core_clk_i=~core_clk_i;
task stop_test;
   if(errors==0&&checks_done>0) $display("NO MISMATCHES");
   else $display("MISMATCHES SEEN");
   $finish;
endtask
task op(input [2:0] c,input p,s,input [1:0] n);
   @(negedge core_clk_i);
   instr_class_i=c;
   pcl_write_i=p;
   skip_taken_i=s;
   while(!(phase_o==2'h3&&!flush_o)) @(negedge core_clk_i);
   `CHK(instr_cycle_end_o,1'b1) // last phase
   `CHK(instr_start_o,n==2'h1) // start only if one cycle
   @(negedge core_clk_i);
   `CHK(phase_o,2'h0) // four clocks per cycle
   `CHK(cycles_o,n) // cycle count
   `CHK(flush_o,n==2'h2) // discard in extra cycle
   `CHK(exec_valid_o,n==2'h1) // no-op in extra cycle
   if(n==2'h2) begin
      repeat(3) @(negedge core_clk_i);
      `CHK(flush_o,1'b1) // discard stands whole cycle
      `CHK(instr_start_o,1'b1) // start after extra cycle
   end
endtask
task plain_one;
   op(3'h0,0,0,2'h1); // plain one
endtask
task branch_two;
   for(int c=1;c<6;c++) op(3'(c),0,0,2'h2); // branch two
endtask
task pcl_extra;
   op(3'h0,1,0,2'h2); // pcl extra
   op(3'h1,1,0,2'h2); // not doubled on jump
   op(3'h6,1,0,2'h2); // pcl on skip
endtask
task skip_count;
   op(3'h6,0,0,2'h1); // skip not taken
   op(3'h6,0,1,2'h2); // skip taken
endtask
task reset_mid;
   @(negedge core_clk_i);
   instr_class_i=3'h1;
   while(!(phase_o==2'h3&&!flush_o)) @(negedge core_clk_i);
   @(negedge core_clk_i);
   nrst_i=0;
   @(negedge core_clk_i);
   `CHK(phase_o,2'h0) // phase restarts
   `CHK(flush_o,1'b0) // discard cleared
   `CHK(exec_valid_o,1'b1) // valid after reset
   `CHK(cycles_o,2'h1) // count after reset
   nrst_i=1;
endtask
initial begin
   repeat(12) @(negedge core_clk_i);
   nrst_i=1;
   plain_one;
   branch_two;
   pcl_extra;
   skip_count;
   reset_mid;
   plain_one;
   stop_test;
end
initial begin
   #20000;
   errors++;
   stop_test;
end
endmodule
